// ### i2c_slave_bus_front_end_test.sv
// self-checking bench for the two-wire slave front end
`timescale 1ns/100ps
module i2c_slave_bus_front_end_test;
   import isf_pkg::*;
   typedef struct {
      logic [7:0] a;
      logic [7:0] d;
      logic       aa;
      logic       da;
      logic [1:0] k;
      int         ne;
   } isf_row_t;
   // ack fields hold the wire level: 0 acknowledged
   isf_row_t rows [8] = '{
      '{8'hCA, 8'h5A, 1'b0, 1'b0, ISF_KIND_DATA, 2},
      '{8'hC2, 8'h5A, 1'b1, 1'b1, ISF_KIND_ADDR, 0},
      '{8'hDA, 8'h5A, 1'b1, 1'b1, ISF_KIND_ADDR, 0},
      '{8'h00, 8'h06, 1'b0, 1'b0, ISF_KIND_GC_RST, 2},
      '{8'h00, 8'h09, 1'b0, 1'b0, ISF_KIND_GC_WAKE, 2},
      '{8'h00, 8'h55, 1'b0, 1'b1, ISF_KIND_ADDR, 1},
      '{8'h01, 8'h00, 1'b1, 1'b1, ISF_KIND_ADDR, 0},
      '{8'hF0, 8'h00, 1'b1, 1'b1, ISF_KIND_ADDR, 0}};
   logic       core_clk = 1'b0;
   logic       link_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       eeprom_idle_flag = 1'b1;
   logic [7:0] tx_data = 8'hA5;
   logic       scl, m_low, sda_o, sda_oe, tx_byte_req, frame_start, frame_stop;
   logic       frame_abort, bus_collision, rx_valid, hs_mode_active;
   logic [7:0] rx_data, last_d;
   logic [1:0] rx_kind, last_k;
   wire        sda = (sda_oe ? sda_o : 1'b1) & ~m_low;
   int         num_errors = 0;
   int         samples_checked = 0;
   int         n_st = 0, n_sp = 0, n_ab = 0, n_co = 0, n_rx = 0, n_tx = 0;

   initial forever #2.5 core_clk = ~core_clk;
   initial begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end

   isf_i2c_slave_front #(.DEV_ADDR_LOW(3'h5)) u_dut (
      .core_clk, .rst_n, .link_clk, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe,
      .eeprom_idle_flag, .tx_data, .tx_byte_req, .frame_start, .frame_stop, .frame_abort,
      .bus_collision, .rx_valid, .rx_data, .rx_kind, .hs_mode_active);
   isf_bus_master u_master (.scl, .sda_low(m_low), .sda);

   always @(negedge core_clk) begin
      if (frame_start === 1'b1) n_st++;
      if (frame_stop === 1'b1) n_sp++;
      if (frame_abort === 1'b1) n_ab++;
      if (bus_collision === 1'b1) n_co++;
      if (tx_byte_req === 1'b1) n_tx++;
      if (rx_valid === 1'b1) begin
         n_rx++;
         last_d = rx_data;
         last_k = rx_kind;
      end
   end

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask : check

   task automatic stop_test;
      $display("checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test

   task automatic settle;
      repeat (20) @(negedge core_clk);
   endtask : settle

   task automatic wframe(input logic [7:0] a, input logic [7:0] d, output logic a1, output logic a2);
      logic [7:0] q;
      u_master.start();
      u_master.xbyte(a, 1'b1, 1'b0, q, a1);
      u_master.xbyte(d, 1'b1, 1'b0, q, a2);
      u_master.stop();
      settle();
   endtask : wframe

   initial begin
      #400_000;
      num_errors++;
      stop_test();
   end

   initial begin
      isf_row_t   r;
      logic [7:0] q;
      logic       a;
      logic       a2;
      int         b;
      int         c;
      int         e;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk) rst_n = 1'b1;
      check("sda_oe", sda_oe, 1'b0);
      check("hs_mode_active", hs_mode_active, 1'b0);
      check("rx_data", {rx_kind, rx_data}, 10'h000);
      settle();
      foreach (rows[i]) begin
         r = rows[i];
         b = n_rx;
         c = n_st + n_sp;
         e = n_ab;
         u_master.start();
         u_master.xbyte(r.a, 1'b1, 1'b0, q, a);
         check("addr ack", a, r.aa);
         if (!r.aa) begin
            u_master.xbyte(r.d, 1'b1, 1'b0, q, a);
            check("data ack", a, r.da);
         end
         u_master.stop();
         settle();
         check("rx count", n_rx - b, r.ne);
         check("frame events", n_st + n_sp - c, 2);
         check("row aborts", n_ab - e, 0);
         if (r.ne != 0) check("rx_data", last_d, r.ne == 2 ? r.d : r.a);
         if (r.ne != 0) check("rx_kind", last_k, r.k);
      end
      // master code, then repeated start at high speed
      u_master.start();
      u_master.xbyte(8'h0B, 1'b1, 1'b0, q, a);
      check("code ack", a, 1'b1);
      u_master.start();
      u_master.xbyte(8'hCA, 1'b1, 1'b0, q, a);
      check("hs addr ack", a, 1'b0);
      check("hs_mode_active", hs_mode_active, 1'b1);
      u_master.stop();
      settle();
      check("hs_mode_active", hs_mode_active, 1'b0);
      // slow master: write, repeated start, two reads with no stretching
      u_master.half = 300;
      b = n_st;
      c = n_tx;
      u_master.start();
      u_master.xbyte(8'hCA, 1'b1, 1'b0, q, a);
      u_master.xbyte(8'h33, 1'b1, 1'b0, q, a);
      u_master.start();
      u_master.xbyte(8'hCB, 1'b1, 1'b0, q, a);
      check("read ack", a, 1'b0);
      u_master.xbyte(8'hFF, 1'b0, 1'b0, q, a);
      check("read byte", q, 8'hA5);
      u_master.xbyte(8'hFF, 1'b1, 1'b0, q, a);
      check("read byte", q, 8'hA5);
      u_master.stop();
      settle();
      check("starts", n_st - b, 2);
      check("tx requests", n_tx - c, 3);
      u_master.half = 100;
      // programming in progress: acked, only the address delivered
      @(negedge core_clk) eeprom_idle_flag = 1'b0;
      b = n_rx;
      wframe(8'hCA, 8'h77, a, a2);
      check("busy acks", {a, a2}, 2'b00);
      check("busy rx", n_rx - b, 1);
      @(negedge core_clk) eeprom_idle_flag = 1'b1;
      // stop after four data bits
      b = n_ab;
      c = n_rx;
      u_master.start();
      u_master.xbyte(8'hCA, 1'b1, 1'b0, q, a);
      repeat (4) u_master.xbit(1'b0, 1'b0, a);
      u_master.stop();
      settle();
      check("abort", n_ab - b, 1);
      check("abort rx", n_rx - c, 1);
      // another driver holds sda low while we send ones, then a clock after the read nack where only start or stop may follow
      @(negedge core_clk) tx_data = 8'hFF;
      b = n_co;
      u_master.start();
      u_master.xbyte(8'hCB, 1'b1, 1'b0, q, a);
      u_master.xbyte(8'hFF, 1'b1, 1'b1, q, a);
      u_master.start();
      u_master.xbyte(8'hCB, 1'b1, 1'b0, q, a);
      u_master.xbyte(8'hFF, 1'b1, 1'b0, q, a);
      u_master.xbit(1'b1, 1'b0, a);
      u_master.stop();
      settle();
      check("collision", n_co - b, 2);
      wframe(8'hCA, 8'h5A, a, a2);
      check("acks after reset", {a, a2}, 2'b00);
      stop_test();
   end
endmodule : i2c_slave_bus_front_end_test

// ### isf_bus_master.sv
// behavioural two-wire bus master: makes scl, pulls sda low, samples the wire
`timescale 1ns/100ps
module isf_bus_master (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   int half = 100;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // from idle, or as repeated start from the low phase after a byte
   task automatic start;
      if (!scl) begin
         sda_low = 1'b0;
         #(half / 2);
         scl = 1'b1;
      end
      #(half / 2);
      sda_low = 1'b1;
      #(half / 2);
      scl = 1'b0;
      #(half / 2);
   endtask : start

   task automatic stop;
      sda_low = 1'b1;
      #(half / 2);
      scl = 1'b1;
      #(half / 2);
      sda_low = 1'b0;
      #half;
   endtask : stop

   // jam pulls sda low against a released one
   task automatic xbit(input logic b, input logic jam, output logic s);
      sda_low = !b || jam;
      #(half / 2);
      scl = 1'b1;
      #(half / 2);
      s = sda;
      #(half / 2);
      scl = 1'b0;
      #(half / 2);
   endtask : xbit

   // msb first, ninth slot driven with last
   task automatic xbyte(input logic [7:0] d, input logic last, input logic jam,
                        output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], jam, q[i]);
      end
      xbit(last, 1'b0, a);
   endtask : xbyte
endmodule : isf_bus_master

// ### isf_front_monitor.sv
// assertion checker bound to the two-wire slave front end
`timescale 1ns/100ps
module isf_front_monitor
   import isf_pkg::*;
#(
   parameter logic [2:0] DEV_ADDR_LOW = 3'h0,
   parameter logic [7:0] GC_RESET_CMD = 8'h06
) (
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       link_clk,
   input wire logic       scl_i,
   input wire logic       sda_o,
   input wire logic       sda_oe,
   input wire logic       frame_start,
   input wire logic       frame_stop,
   input wire logic       frame_abort,
   input wire logic       bus_collision,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic [1:0] rx_kind
);
   sda_edge_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      $changed(sda_oe) |-> !scl_i) else $error("sda drive moved while scl high");
   ack_hold_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      $rose(sda_oe) |=> sda_oe [*8]) else $error("sda drive released too early");
   open_drain_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      sda_oe |-> !sda_o) else $error("sda driven high");
   start_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      frame_start |=> !frame_start) else $error("start pulse too long");
   stop_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      frame_stop |=> !frame_stop) else $error("stop pulse too long");
   abort_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      frame_abort |=> !frame_abort) else $error("abort pulse too long");
   coll_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      bus_collision |=> !bus_collision) else $error("collision pulse too long");
   addr_match_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      rx_valid && rx_kind == ISF_KIND_ADDR |-> rx_data[7:1] == {ISF_ADDR_FIXED, DEV_ADDR_LOW}
         || rx_data[7:1] == ISF_GC_ADDR) else $error("foreign address delivered");
   gc_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      rx_valid && rx_kind == ISF_KIND_GC_RST |-> rx_data == GC_RESET_CMD) else $error("bad reset command");
   cover property (@(posedge core_clk) rx_valid && rx_kind == ISF_KIND_DATA);
   cover property (@(posedge core_clk) rx_valid && rx_kind == ISF_KIND_GC_WAKE);
   cover property (@(posedge core_clk) bus_collision);
   cover property (@(posedge core_clk) frame_abort);
endmodule : isf_front_monitor

bind isf_i2c_slave_front isf_front_monitor #(
   .DEV_ADDR_LOW(DEV_ADDR_LOW),
   .GC_RESET_CMD(GC_RESET_CMD)
) u_mon (
   .core_clk, .rst_n, .link_clk, .scl_i, .sda_o, .sda_oe, .frame_start, .frame_stop,
   .frame_abort, .bus_collision, .rx_valid, .rx_data, .rx_kind
);

// ### isf_i2c_slave_front.sv
// two-wire slave front end: link-side protocol engine and core-side event delivery
`timescale 1ns/100ps
// Functional notes
// RULE1 - only seven-bit addresses are matched; no ten-bit addressing form
// RULE2 - start is SDA falling while SCL stays high
// RULE3 - stop is SDA rising while SCL stays high
// RULE4 - stop returns the whole serial engine to idle
// RULE5 - SDA driven by us changes only after SCL falls
// RULE6 - after eight received bits we pull SDA low in the ninth slot
// RULE7 - not-acknowledge means leaving SDA released
// RULE8 - after an error the master must send a new start
// RULE9 - acknowledge general call and own address, nothing else
// RULE10 - address and command bytes still acknowledged during nonvolatile write
// RULE11 - collision resets the engine; collision during start has no effect
// RULE12 - repeated start continues the frame with a fresh address byte
// RULE13 - repeated start collision: SCL falling before SDA goes low
// RULE14 - SCL is never driven; read data is prefetched ahead of time
// RULE15 - unexpected start or stop mid-byte aborts the transfer
// RULE16 - address is fixed upper nibble plus three variant bits
// RULE17 - first byte after start is address plus direction bit
// RULE18 - master code 00001xxx is not acknowledged but enters high speed
// RULE19 - high speed lasts until the next stop
// RULE20 - works at 100 kHz, 400 kHz and 3.4 MHz SCL rates
// RULE21 - general call reset and wake-up commands are recognised
// RULE22 - received SDA is taken at each SCL rising edge
// RULE23 - during nonvolatile programming only reads reach the core; the code still delivers address bytes and drops data and command bytes
// RULE24 - after master code the next byte is a normal address
// RULE25 - acknowledge held from falling edge after bit eight to next fall
// RULE26 - pins oversampled by a synchronised fast link sample clock
module isf_i2c_slave_front
   import isf_pkg::*;
#(
   parameter logic [2:0]  DEV_ADDR_LOW  = 3'h0,
   parameter logic [7:0]  GC_RESET_CMD  = 8'h06,
   parameter logic [7:0]  GC_WAKE_CMD   = 8'h09,
   parameter int unsigned FILTER_CYCLES = 1
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       link_clk,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   input  wire logic       eeprom_idle_flag,
   input  wire logic [7:0] tx_data,
   output logic            tx_byte_req,
   output logic            frame_start,
   output logic            frame_stop,
   output logic            frame_abort,
   output logic            bus_collision,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic [1:0]      rx_kind,
   output logic            hs_mode_active
);

   localparam logic [2:0] FILT_LAST = 3'(FILTER_CYCLES - 1);

   function automatic logic addr_hit(input logic [7:0] b);
      // own address any direction, general call only as a write
      return (b[7:1] == {ISF_ADDR_FIXED, DEV_ADDR_LOW}) || (b == {ISF_GC_ADDR, 1'b0}); // RULE1 RULE9 RULE16
   endfunction : addr_hit

   function automatic logic is_master_code(input logic [7:0] b);
      return b[7:3] == ISF_MC_PREFIX; // RULE18
   endfunction : is_master_code

   // link domain
   logic [ISF_PIN_W-1:0] lk_sync;
   logic [1:0]           pin_filt;
   logic [2:0]           filt_cnt [2];
   logic                 scl_d;
   logic                 sda_d;
   logic                 scl_s;
   logic                 sda_s;
   logic                 nvm_idle;
   logic                 scl_rise;
   logic                 scl_fall;
   logic                 start_cond;
   logic                 stop_cond;
   logic                 mid_byte;
   logic                 byte_done;

   isf_state_t           state;
   logic [3:0]           bit_cnt;
   logic [7:0]           shift;
   logic                 first_byte;
   logic                 read_dir;
   logic                 gc_frame;
   logic                 gc_taken;
   logic                 mack;
   logic                 hs_mode_lk;
   logic                 ev_byte;
   logic                 ev_abort;
   logic                 ev_coll;
   logic                 ev_txreq;
   logic [7:0]           evt_data;
   logic [1:0]           evt_kind;
   logic                 start_tgl;
   logic                 stop_tgl;
   logic                 abort_tgl;
   logic                 byte_tgl;
   logic                 coll_tgl;
   logic                 txreq_tgl;

   // core-domain register read by the link engine; see prefetch note below
   logic [7:0]           tx_hold;

   // pins and the programming flag enter through two flops
   isf_sync #(
      .WIDTH     (ISF_PIN_W),
      .RESET_VAL (3'h7)
   ) u_link_sync (
      .clk   (link_clk),
      .rst_n (rst_n),
      .din   ({eeprom_idle_flag, sda_i, scl_i}),
      .dout  (lk_sync)
   ); // RULE26

   // a level change must persist FILTER_CYCLES samples to be accepted
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_filt    <= 2'h3;
         filt_cnt[0] <= 3'h0;
         filt_cnt[1] <= 3'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (lk_sync[i] == pin_filt[i]) begin
               filt_cnt[i] <= 3'h0;
            end else if (filt_cnt[i] == FILT_LAST) begin
               pin_filt[i] <= lk_sync[i];
               filt_cnt[i] <= 3'h0;
            end else begin
               filt_cnt[i] <= filt_cnt[i] + 3'h1;
            end
         end
      end
   end // RULE26

   assign scl_s    = pin_filt[ISF_PIN_SCL];
   assign sda_s    = pin_filt[ISF_PIN_SDA];
   assign nvm_idle = lk_sync[ISF_PIN_IDLE];

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise   = scl_s & ~scl_d;
   assign scl_fall   = ~scl_s & scl_d;
   assign start_cond = scl_s & scl_d & sda_d & ~sda_s; // RULE2 RULE12
   assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s; // RULE3
   // count moves at the rise, so a count of one with scl high is only a start/stop setup
   assign mid_byte   = ((state == ISF_RX) || (state == ISF_TX)) && (bit_cnt > 4'h1);
   assign byte_done  = scl_fall && (bit_cnt == ISF_BYTE_BITS);

   // protocol engine; start and stop override every state
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= ISF_IDLE;
         bit_cnt    <= 4'h0;
         shift      <= 8'h00;
         first_byte <= 1'b0;
         read_dir   <= 1'b0;
         gc_frame   <= 1'b0;
         gc_taken   <= 1'b0;
         mack       <= 1'b0;
         sda_oe     <= 1'b0;
         ev_byte    <= 1'b0;
         ev_abort   <= 1'b0;
         ev_coll    <= 1'b0;
         ev_txreq   <= 1'b0;
         evt_data   <= 8'h00;
         evt_kind   <= ISF_KIND_ADDR;
      end else begin
         ev_byte  <= 1'b0;
         ev_abort <= 1'b0;
         ev_coll  <= 1'b0;
         ev_txreq <= 1'b0;
         if (stop_cond) begin
            state    <= ISF_IDLE; // RULE4
            sda_oe   <= 1'b0;
            bit_cnt  <= 4'h0;
            ev_abort <= mid_byte; // RULE15
         end else if (start_cond) begin
            // a collision seen during the start itself is simply dropped here
            state      <= ISF_RX; // RULE8 RULE11 RULE12
            bit_cnt    <= 4'h0;
            first_byte <= 1'b1; // RULE17 RULE24
            gc_frame   <= 1'b0;
            gc_taken   <= 1'b0;
            sda_oe     <= 1'b0;
            ev_abort   <= mid_byte; // RULE15
         end else begin
            unique case (state)
               ISF_IDLE, ISF_SKIP: begin
               end
               ISF_RX: begin
                  if (scl_rise) begin
                     shift   <= {shift[6:0], sda_s}; // RULE22
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (byte_done) begin
                     bit_cnt  <= 4'h0;
                     evt_data <= shift;
                     if (first_byte) begin
                        first_byte <= 1'b0;
                        read_dir   <= shift[ISF_RW_BIT];
                        if (is_master_code(shift)) begin
                           state <= ISF_SKIP; // RULE18 RULE7
                        end else if (addr_hit(shift)) begin
                           state    <= ISF_ACK;
                           sda_oe   <= 1'b1; // RULE6 RULE10 RULE25
                           ev_byte  <= 1'b1;
                           evt_kind <= ISF_KIND_ADDR;
                           ev_txreq <= shift[ISF_RW_BIT]; // RULE14
                           gc_frame <= (shift[7:1] == ISF_GC_ADDR); // RULE21
                        end else begin
                           state <= ISF_SKIP; // RULE7 RULE9
                        end
                     end else if (gc_frame) begin
                        // one general call command per address; later ones refused
                        if (!gc_taken && ((shift == GC_RESET_CMD) || (shift == GC_WAKE_CMD))) begin
                           state    <= ISF_ACK;
                           sda_oe   <= 1'b1; // RULE10
                           gc_taken <= 1'b1;
                           ev_byte  <= nvm_idle; // RULE23
                           evt_kind <= (shift == GC_RESET_CMD) ? ISF_KIND_GC_RST : ISF_KIND_GC_WAKE; // RULE21
                        end else begin
                           state <= ISF_SKIP; // RULE7
                        end
                     end else begin
                        state    <= ISF_ACK;
                        sda_oe   <= 1'b1; // RULE6 RULE10
                        ev_byte  <= nvm_idle; // RULE23
                        evt_kind <= ISF_KIND_DATA;
                     end
                  end
               end
               ISF_ACK: begin
                  if (scl_fall) begin
                     bit_cnt <= 4'h0;
                     if (read_dir) begin
                        state    <= ISF_TX;
                        shift    <= tx_hold;
                        sda_oe   <= ~tx_hold[7]; // RULE5 RULE14
                        ev_txreq <= 1'b1;
                     end else begin
                        state  <= ISF_RX;
                        sda_oe <= 1'b0; // RULE25
                     end
                  end
               end
               ISF_TX: begin
                  if (scl_rise) begin
                     bit_cnt <= bit_cnt + 4'h1;
                     if (!sda_oe && !sda_s) begin
                        // another transmitter holds the line low: give up the frame
                        state   <= ISF_SKIP; // RULE11
                        ev_coll <= 1'b1;
                     end
                  end else if (byte_done) begin
                     state  <= ISF_MACK;
                     sda_oe <= 1'b0;
                  end else if (scl_fall) begin
                     shift  <= {shift[6:0], 1'b0};
                     sda_oe <= ~shift[6]; // RULE5
                  end
               end
               ISF_MACK: begin
                  if (scl_rise) begin
                     mack <= ~sda_s; // RULE22
                  end else if (scl_fall) begin
                     bit_cnt <= 4'h0;
                     if (mack) begin
                        state    <= ISF_TX;
                        shift    <= tx_hold;
                        sda_oe   <= ~tx_hold[7]; // RULE14
                        ev_txreq <= 1'b1;
                     end else begin
                        state <= ISF_WAIT;
                     end
                  end
               end
               ISF_WAIT: begin
                  // only a repeated start or a stop may follow; a clock means contention
                  if (scl_fall) begin
                     state   <= ISF_SKIP; // RULE13 RULE11
                     ev_coll <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // high-speed flag lives until the next stop
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         hs_mode_lk <= 1'b0;
      end else if (stop_cond) begin
         hs_mode_lk <= 1'b0; // RULE19
      end else if ((state == ISF_RX) && first_byte && byte_done && is_master_code(shift)) begin
         hs_mode_lk <= 1'b1; // RULE18
      end
   end

   // one toggle per event kind so close events cannot merge
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_tgl <= 1'b0;
         stop_tgl  <= 1'b0;
         abort_tgl <= 1'b0;
         byte_tgl  <= 1'b0;
         coll_tgl  <= 1'b0;
         txreq_tgl <= 1'b0;
      end else begin
         start_tgl <= start_tgl ^ start_cond;
         stop_tgl  <= stop_tgl ^ stop_cond;
         abort_tgl <= abort_tgl ^ ev_abort;
         byte_tgl  <= byte_tgl ^ ev_byte;
         coll_tgl  <= coll_tgl ^ ev_coll;
         txreq_tgl <= txreq_tgl ^ ev_txreq;
      end
   end

   // open-drain: only ever drive low; SCL has no driver at all
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0; // RULE14
      end
   end

   // core domain
   logic [ISF_EV_W-1:0] ck_sync;
   logic [ISF_EV_W-1:0] ck_prev;
   logic [ISF_EV_W-1:0] ck_edge;

   isf_sync #(
      .WIDTH     (ISF_EV_W),
      .RESET_VAL (7'h00)
   ) u_core_sync (
      .clk   (core_clk),
      .rst_n (rst_n),
      .din   ({txreq_tgl, hs_mode_lk, coll_tgl, byte_tgl, abort_tgl, stop_tgl, start_tgl}),
      .dout  (ck_sync)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ck_prev <= 7'h00;
      end else begin
         ck_prev <= ck_sync;
      end
   end

   assign ck_edge = ck_sync ^ ck_prev;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_start    <= 1'b0;
         frame_stop     <= 1'b0;
         frame_abort    <= 1'b0;
         bus_collision  <= 1'b0;
         rx_valid       <= 1'b0;
         tx_byte_req    <= 1'b0;
         hs_mode_active <= 1'b0;
      end else begin
         frame_start    <= ck_edge[ISF_EV_START];
         frame_stop     <= ck_edge[ISF_EV_STOP];
         frame_abort    <= ck_edge[ISF_EV_ABORT];
         bus_collision  <= ck_edge[ISF_EV_COLL];
         rx_valid       <= ck_edge[ISF_EV_BYTE];
         tx_byte_req    <= ck_edge[ISF_EV_TXREQ];
         hs_mode_active <= ck_sync[ISF_EV_HS];
      end
   end

   // evt_data is frozen for a whole byte time, far longer than the toggle delay
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_data <= 8'h00;
         rx_kind <= ISF_KIND_ADDR;
      end else if (ck_edge[ISF_EV_BYTE]) begin
         rx_data <= evt_data;
         rx_kind <= evt_kind;
      end
   end

   // prefetch: next byte captured a byte time before the engine loads it (the first one during the address ack slot),
   // so the line is never held waiting on the core
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_hold <= 8'hFF;
      end else if (ck_edge[ISF_EV_TXREQ]) begin
         tx_hold <= tx_data; // RULE14 RULE20
      end
   end

endmodule : isf_i2c_slave_front

// ### isf_pkg.sv
// constants, field positions and types shared by the two-wire slave front end
package isf_pkg;

   // address byte layout
   localparam logic [3:0] ISF_ADDR_FIXED   = 4'hC;
   localparam logic [6:0] ISF_GC_ADDR      = 7'h00;
   localparam logic [4:0] ISF_MC_PREFIX    = 5'h01;
   localparam logic [3:0] ISF_BYTE_BITS    = 4'h8;
   localparam int         ISF_RW_BIT       = 0;

   // kinds of received byte reported to the core side
   localparam logic [1:0] ISF_KIND_ADDR    = 2'h0;
   localparam logic [1:0] ISF_KIND_DATA    = 2'h1;
   localparam logic [1:0] ISF_KIND_GC_RST  = 2'h2;
   localparam logic [1:0] ISF_KIND_GC_WAKE = 2'h3;

   // bit positions of the link-to-core crossing word
   localparam int         ISF_EV_START     = 0;
   localparam int         ISF_EV_STOP      = 1;
   localparam int         ISF_EV_ABORT     = 2;
   localparam int         ISF_EV_BYTE      = 3;
   localparam int         ISF_EV_COLL      = 4;
   localparam int         ISF_EV_HS        = 5;
   localparam int         ISF_EV_TXREQ     = 6;
   localparam int         ISF_EV_W         = 7;

   // bit positions of the link-side input synchroniser
   localparam int         ISF_PIN_SCL      = 0;
   localparam int         ISF_PIN_SDA      = 1;
   localparam int         ISF_PIN_IDLE     = 2;
   localparam int         ISF_PIN_W        = 3;

   // supported bus rates and the core clock that must cover them
   localparam int         ISF_SM_SCL_KHZ   = 100;
   localparam int         ISF_FM_SCL_KHZ   = 400;
   localparam int         ISF_HS_SCL_KHZ   = 3400;
   localparam int         ISF_CORE_CLK_MHZ = 200;
   localparam int         ISF_HS_HALF_PS   = 1_000_000_000 / (2 * ISF_HS_SCL_KHZ);

   typedef enum logic [2:0] {
      ISF_IDLE,
      ISF_RX,
      ISF_ACK,
      ISF_TX,
      ISF_MACK,
      ISF_WAIT,
      ISF_SKIP
   } isf_state_t;

endpackage : isf_pkg

// ### isf_sync.sv
// two flip-flop level synchroniser, one bit per lane
`timescale 1ns/100ps
module isf_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   // only the second stage may read this
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RESET_VAL;
         dout <= RESET_VAL;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule : isf_sync
